// >>> inc/rccs_defs.svh
`ifndef RCCS_DEFS_SVH
`define RCCS_DEFS_SVH

// array size: one register cell per quadrant
`define RCCS_NCELL      4
// clock pads: routed a, routed b, quadrant a..d
`define RCCS_NPIN       6
`define RCCS_AW         8
`define RCCS_DW         32

// register byte offsets
`define RCCS_OFS_CTRL   8'h00
`define RCCS_OFS_CELL   8'h04
`define RCCS_OFS_PIN    8'h08
`define RCCS_OFS_STAT   8'h0c
`define RCCS_OFS_TT0    8'h10

// control register fields
`define RCCS_CTRL_LARGE 0
`define RCCS_CTRL_RA_INT 1
`define RCCS_CTRL_RB_INT 2
`define RCCS_CTRL_RA_IO 3
`define RCCS_CTRL_RB_IO 4
`define RCCS_CTRL_QUSE  8
`define RCCS_CTRL_QINT  12

// per-cell configuration byte fields
`define RCCS_CELL_W     8
`define RCCS_CELL_SRC   0
`define RCCS_CELL_POL   3
`define RCCS_CELL_QSEL  4
`define RCCS_CELL_INV   6

// pin register and status fields
`define RCCS_PIN_OE     8
`define RCCS_STAT_PIN   4
`define RCCS_STAT_NETA  10
`define RCCS_STAT_NETB  11
`define RCCS_STAT_QNET  12
`define RCCS_STAT_IO    16

// reset values
`define RCCS_CTRL_RST   32'h0000_0000
`define RCCS_CELL_RST   32'h0000_0000
`define RCCS_PIN_RST    32'h0000_0000
`define RCCS_TT_RST     32'h0000_0000

`endif

// >>> inc/rccs_pkg.sv
`include "rccs_defs.svh"

package rccs_pkg;
	// clock origin of a register cell
	typedef enum logic [2:0] {
		RCCS_SRC_HARD   = 3'h0,
		RCCS_SRC_ROUTA  = 3'h1,
		RCCS_SRC_ROUTB  = 3'h2,
		RCCS_SRC_QUAD   = 3'h3,
		RCCS_SRC_INTERN = 3'h4
	} rccs_src_t;

	// register cell state
	typedef struct packed {
		logic q;
		logic clk_prev;
	} rccs_cell_st_t;

	// top-level state
	typedef struct packed {
		logic [`RCCS_DW-1:0]                   ctrl;
		logic [`RCCS_DW-1:0]                   cell_cfg;
		logic [`RCCS_DW-1:0]                   pin_cfg;
		logic [`RCCS_NCELL-1:0][`RCCS_DW-1:0]  truth;
		logic [`RCCS_DW-1:0]                   rdata;
		logic [`RCCS_NPIN-1:0]                 pin_out;
		logic [`RCCS_NPIN-1:0]                 pin_oe;
	} rccs_top_st_t;
endpackage

// >>> logic/rccs_clock_fabric.sv
`timescale 1ns/100ps
`include "rccs_defs.svh"


module rccs_clock_fabric (
	input  wire logic                       ref_clk_i,
	input  wire logic                       sys_rst_i,
	input  wire logic [`RCCS_AW-1:0]        reg_addr_i,
	input  wire logic [`RCCS_DW-1:0]        reg_wdata_i,
	input  wire logic                       reg_wr_i,
	input  wire logic                       reg_rd_i,
	output logic      [`RCCS_DW-1:0]        reg_rdata_o,
	input  wire logic                       hardwired_clock_i,
	input  wire logic [`RCCS_NPIN-1:0]      clk_pin_i,
	output logic      [`RCCS_NPIN-1:0]      clk_pin_o,
	output logic      [`RCCS_NPIN-1:0]      clk_pin_oe_o,
	input  wire logic [3*`RCCS_NCELL-1:0]   cell_data_i,
	input  wire logic [`RCCS_NCELL-1:0]     invertible_logic_input_i,
	input  wire logic [`RCCS_NCELL-1:0]     enable_select_0_i,
	input  wire logic [`RCCS_NCELL-1:0]     enable_select_1_i,
	input  wire logic [`RCCS_NCELL-1:0]     async_clear_i,
	input  wire logic [`RCCS_NCELL-1:0]     async_preset_i,
	output logic      [`RCCS_NCELL-1:0]     cell_q_o
);
	import rccs_pkg::*;

	rccs_top_st_t st;      // all registered state
	rccs_top_st_t next_st; // its next value

	// clock networks and fabric nets
	logic                         routed_clock_a;  // routed network a
	logic                         routed_clock_b;  // routed network b
	logic [`RCCS_NCELL-1:0]       quad_net;        // quadrant networks a..d
	logic [`RCCS_NPIN-1:0]        io_mask;         // pads working as plain I/O
	logic [`RCCS_NCELL-1:0]       logic_out;       // combinational cell outputs
	logic [`RCCS_NCELL-1:0]       cell_clk;        // selected clock per cell
	logic [`RCCS_NCELL-1:0][4:0]  cell_in;         // lookup inputs per cell

	// one cell's configuration byte
	function automatic logic [`RCCS_CELL_W-1:0] cfg_of(
		input logic [`RCCS_DW-1:0] cfg,
		input int                  idx
	);
		cfg_of = cfg[idx*`RCCS_CELL_W +: `RCCS_CELL_W];
	endfunction

	// byte offset of a truth table register
	function automatic logic [`RCCS_AW-1:0] tt_ofs(input int idx);
		tt_ofs = `RCCS_OFS_TT0 + `RCCS_AW'(4 * idx);
	endfunction

	// which pads act as I/O for a given control word
	function automatic logic [`RCCS_NPIN-1:0] io_of(input logic [`RCCS_DW-1:0] c);
		logic lg;
		lg = c[`RCCS_CTRL_LARGE];
		io_of[0] = lg & c[`RCCS_CTRL_RA_IO];
		io_of[1] = lg & c[`RCCS_CTRL_RB_IO];
		// a quadrant pad is I/O unless claimed as a clock
		io_of[5:2] = ~({4{lg}} & c[`RCCS_CTRL_QUSE +: 4]);
	endfunction

	// clock mux of one register cell
	function automatic logic pick_clk(
		input logic [2:0] src,
		input logic [1:0] qsel,
		input logic       hard,
		input logic       ra,
		input logic       rb,
		input logic [3:0] qn,
		input logic       intern
	);
		case (src)
			RCCS_SRC_HARD:   pick_clk = hard;
			RCCS_SRC_ROUTA:  pick_clk = ra;
			RCCS_SRC_ROUTB:  pick_clk = rb;
			// several cells may share one quadrant clock
			RCCS_SRC_QUAD:   pick_clk = qn[qsel];
			RCCS_SRC_INTERN: pick_clk = intern;
			// undefined codes park the clock low
			default:         pick_clk = 1'b0;
		endcase
	endfunction

	// io mask follows the live control register
	assign io_mask = io_of(st.ctrl);

	// routed networks: pin or internal logic, silent when pad is I/O
	// internal origin is the cell register, so net a never loops through a lookup
	always_comb begin
		if (io_mask[0]) begin
			routed_clock_a = 1'b0;
		end else if (st.ctrl[`RCCS_CTRL_RA_INT]) begin
			routed_clock_a = cell_q_o[0];
		end else begin
			routed_clock_a = clk_pin_i[0];
		end
		if (io_mask[1]) begin
			routed_clock_b = 1'b0;
		end else if (st.ctrl[`RCCS_CTRL_RB_INT]) begin
			routed_clock_b = cell_q_o[1];
		end else begin
			routed_clock_b = clk_pin_i[1];
		end
	end

	// quadrant networks exist only on the large variant
	always_comb begin
		for (int j = 0; j < `RCCS_NCELL; j++) begin
			if (io_mask[2+j]) begin
				quad_net[j] = 1'b0;
			end else if (st.ctrl[`RCCS_CTRL_QINT+j]) begin
				quad_net[j] = logic_out[j];
			end else begin
				quad_net[j] = clk_pin_i[2+j];
			end
		end
	end

	// cell array: lookup cell feeds register cell
	for (genvar i = 0; i < `RCCS_NCELL; i++) begin : g_cell
		localparam int NXT = (i + 1) % `RCCS_NCELL;

		// routed clock a may enter logic, the hardwired clock never does
		assign cell_in[i] = {invertible_logic_input_i[i],
			cell_data_i[3*i +: 3], routed_clock_a};

		rccs_logic_cell u_lc (
			.in_i    (cell_in[i]),
			.truth_i (st.truth[i]),
			.inv_i   (st.cell_cfg[i*`RCCS_CELL_W + `RCCS_CELL_INV]),
			.out_o   (logic_out[i])
		);

		logic [`RCCS_CELL_W-1:0] cfg_b;  // this cell's configuration byte
		logic [2:0]              src_b;  // clock origin code
		logic [1:0]              qsel_b; // quadrant clock index

		// a function result cannot be part-selected, so land it on a net first
		assign cfg_b = cfg_of(st.cell_cfg, i);
		assign src_b = cfg_b[`RCCS_CELL_SRC +: 3];
		assign qsel_b = cfg_b[`RCCS_CELL_QSEL +: 2];

		// internal clock origin is the neighbour's logic output
		assign cell_clk[i] = pick_clk(src_b, qsel_b,
			hardwired_clock_i, routed_clock_a, routed_clock_b,
			quad_net, logic_out[NXT]);

		rccs_reg_cell u_rc (
			.ref_clk_i (ref_clk_i),
			.sys_rst_i (sys_rst_i),
			.sel_clk_i (cell_clk[i]),
			.fall_i    (st.cell_cfg[i*`RCCS_CELL_W + `RCCS_CELL_POL]),
			.d_i       (logic_out[i]),
			.es0_i     (enable_select_0_i[i]),
			.es1_i     (enable_select_1_i[i]),
			.clr_i     (async_clear_i[i]),
			.pre_i     (async_preset_i[i]),
			.q_o       (cell_q_o[i])
		);

		// every origin code puts the matching net on the cell clock
		a_pick_hard: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
			src_b == RCCS_SRC_HARD |-> cell_clk[i] == hardwired_clock_i)
			else $error("hardwired origin not on cell clock");
		a_pick_routa: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
			src_b == RCCS_SRC_ROUTA |-> cell_clk[i] == routed_clock_a)
			else $error("routed origin a not on cell clock");
		a_pick_routb: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
			src_b == RCCS_SRC_ROUTB |-> cell_clk[i] == routed_clock_b)
			else $error("routed origin b not on cell clock");
		a_pick_quad: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
			src_b == RCCS_SRC_QUAD |-> cell_clk[i] == quad_net[qsel_b])
			else $error("quadrant origin not on cell clock");
		a_pick_intern: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
			src_b == RCCS_SRC_INTERN |-> cell_clk[i] == logic_out[NXT])
			else $error("internal origin not on cell clock");
		// spare codes must never clock the cell
		a_pick_park: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
			src_b > 3'h4 |-> !cell_clk[i])
			else $error("spare origin code clocks the cell");
		// a truth table write lands on its own cell
		a_tt_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
			reg_wr_i && reg_addr_i == tt_ofs(i) |=> st.truth[i] == $past(reg_wdata_i))
			else $error("truth table write lost");
	end

	// register writes, read mux and pad drive
	always_comb begin
		logic [`RCCS_DW-1:0] rd_val;
		rd_val = '0;
		next_st = st;
		// writes land at the edge that closes the strobe cycle
		if (reg_wr_i) begin
			case (reg_addr_i)
				`RCCS_OFS_CTRL: next_st.ctrl = reg_wdata_i;
				`RCCS_OFS_CELL: next_st.cell_cfg = reg_wdata_i;
				`RCCS_OFS_PIN:  next_st.pin_cfg = reg_wdata_i;
				default: begin
					for (int i = 0; i < `RCCS_NCELL; i++) begin
						if (reg_addr_i == tt_ofs(i)) begin
							next_st.truth[i] = reg_wdata_i;
						end
					end
				end
			endcase
		end
		// unmapped reads answer zero
		case (reg_addr_i)
			`RCCS_OFS_CTRL: rd_val = st.ctrl;
			`RCCS_OFS_CELL: rd_val = st.cell_cfg;
			`RCCS_OFS_PIN:  rd_val = st.pin_cfg;
			`RCCS_OFS_STAT: begin
				rd_val[`RCCS_NCELL-1:0] = cell_q_o;
				rd_val[`RCCS_STAT_PIN +: `RCCS_NPIN] = clk_pin_i;
				rd_val[`RCCS_STAT_NETA] = routed_clock_a;
				rd_val[`RCCS_STAT_NETB] = routed_clock_b;
				rd_val[`RCCS_STAT_QNET +: `RCCS_NCELL] = quad_net;
				rd_val[`RCCS_STAT_IO +: `RCCS_NPIN] = io_mask;
			end
			default: begin
				for (int i = 0; i < `RCCS_NCELL; i++) begin
					if (reg_addr_i == tt_ofs(i)) begin
						rd_val = st.truth[i];
					end
				end
			end
		endcase
		// read data stand only in the cycle after the strobe
		next_st.rdata = reg_rd_i ? rd_val : '0;
		// pads drive only in I/O mode; uses the new control so
		// mode and drive switch on the same edge
		next_st.pin_out = next_st.pin_cfg[`RCCS_NPIN-1:0];
		next_st.pin_oe = next_st.pin_cfg[`RCCS_PIN_OE +: `RCCS_NPIN]
			& io_of(next_st.ctrl);
	end

	// single state register
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			st.ctrl <= `RCCS_CTRL_RST;
			st.cell_cfg <= `RCCS_CELL_RST;
			st.pin_cfg <= `RCCS_PIN_RST;
			st.truth <= {`RCCS_NCELL{`RCCS_TT_RST}};
			st.rdata <= '0;
			st.pin_out <= '0;
			st.pin_oe <= '0;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state flops
	assign reg_rdata_o = st.rdata;
	assign clk_pin_o = st.pin_out;
	assign clk_pin_oe_o = st.pin_oe;

	a_routed_io_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!st.ctrl[`RCCS_CTRL_LARGE] |-> clk_pin_oe_o[1:0] == 2'b00)
		else $error("routed pad driven on small variant");
	a_quad_clk_nodrv: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		st.ctrl[`RCCS_CTRL_LARGE] && st.ctrl[`RCCS_CTRL_QUSE]
		|-> !clk_pin_oe_o[2]) else $error("quadrant clock pad driven");
	a_quad_net_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!st.ctrl[`RCCS_CTRL_LARGE] |-> quad_net == 4'h0)
		else $error("quadrant clock on small variant");
	a_status_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		reg_rd_i && reg_addr_i == `RCCS_OFS_STAT
		|=> reg_rdata_o[`RCCS_NCELL-1:0] == $past(cell_q_o))
		else $error("status read wrong");
	a_rdata_idle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!reg_rd_i |=> reg_rdata_o == '0) else $error("read data outside slot");
	a_hard_select: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		st.cell_cfg[2:0] == RCCS_SRC_HARD |-> cell_clk[0] == hardwired_clock_i)
		else $error("hardwired clock not selected");

	// routed networks follow their chosen origin
	a_routed_a_pin: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!io_mask[0] && !st.ctrl[`RCCS_CTRL_RA_INT]
		|-> routed_clock_a == clk_pin_i[0]) else $error("routed net a not from its pad");
	a_routed_a_int: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!io_mask[0] && st.ctrl[`RCCS_CTRL_RA_INT]
		|-> routed_clock_a == cell_q_o[0]) else $error("routed net a not from logic");
	a_routed_b_pin: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!io_mask[1] && !st.ctrl[`RCCS_CTRL_RB_INT]
		|-> routed_clock_b == clk_pin_i[1]) else $error("routed net b not from its pad");
	a_routed_b_int: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!io_mask[1] && st.ctrl[`RCCS_CTRL_RB_INT]
		|-> routed_clock_b == cell_q_o[1]) else $error("routed net b not from logic");
	// a routed pad working as I/O leaves its network quiet
	a_routed_a_io: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		io_mask[0] |-> !routed_clock_a) else $error("routed net a live on I/O pad");
	a_routed_b_io: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		io_mask[1] |-> !routed_clock_b) else $error("routed net b live on I/O pad");
	// small variant: routed pads stay clocks, quadrant pads are plain I/O
	a_small_no_io: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!st.ctrl[`RCCS_CTRL_LARGE] |-> io_mask[1:0] == 2'b00)
		else $error("routed pad as I/O on small variant");
	a_small_quad_io: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!st.ctrl[`RCCS_CTRL_LARGE] |-> io_mask[5:2] == 4'hf)
		else $error("quadrant pad not I/O on small variant");
	// pads drive only where the mask allows, with the written values
	a_pad_oe_mask: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clk_pin_oe_o == (st.pin_cfg[`RCCS_PIN_OE +: `RCCS_NPIN] & io_mask))
		else $error("pad drive outside I/O mask");
	a_pad_value: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clk_pin_o == st.pin_cfg[`RCCS_NPIN-1:0])
		else $error("pad value differs from pin register");
	// register writes land at the strobe edge, status ignores them
	a_ctrl_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == `RCCS_OFS_CTRL |=> st.ctrl == $past(reg_wdata_i))
		else $error("control write lost");
	a_cell_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == `RCCS_OFS_CELL |=> st.cell_cfg == $past(reg_wdata_i))
		else $error("cell configuration write lost");
	a_pin_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == `RCCS_OFS_PIN |=> st.pin_cfg == $past(reg_wdata_i))
		else $error("pin register write lost");
	a_stat_no_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == `RCCS_OFS_STAT
		|=> $stable(st.ctrl) && $stable(st.cell_cfg) && $stable(st.pin_cfg))
		else $error("status write changed a register");
	a_ctrl_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		reg_rd_i && reg_addr_i == `RCCS_OFS_CTRL |=> reg_rdata_o == $past(st.ctrl))
		else $error("control read wrong");

	// quadrant networks, one set of checks per network
	for (genvar j = 0; j < `RCCS_NCELL; j++) begin : g_quad_chk
		a_quad_pin: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
			!io_mask[2+j] && !st.ctrl[`RCCS_CTRL_QINT+j]
			|-> quad_net[j] == clk_pin_i[2+j]) else $error("quadrant net not from its pad");
		a_quad_int: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
			!io_mask[2+j] && st.ctrl[`RCCS_CTRL_QINT+j]
			|-> quad_net[j] == logic_out[j]) else $error("quadrant net not from logic");
		a_quad_io: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
			io_mask[2+j] |-> !quad_net[j]) else $error("quadrant net live on I/O pad");
		a_quad_nodrv: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
			st.ctrl[`RCCS_CTRL_LARGE] && st.ctrl[`RCCS_CTRL_QUSE+j]
			|-> !clk_pin_oe_o[2+j]) else $error("claimed quadrant pad driven");
	end
endmodule

// >>> logic/rccs_logic_cell.sv
`timescale 1ns/100ps
`include "rccs_defs.svh"

// five-input lookup cell; input 4 has its own inverter
module rccs_logic_cell (
	input  wire logic [4:0]  in_i,
	input  wire logic [31:0] truth_i,
	input  wire logic        inv_i,
	output logic             out_o
);
	import rccs_pkg::*;

	logic [4:0] idx;   // table index after inversion

	// the inverter lets one cell hold a 3-input xor
	always_comb begin
		idx = {in_i[4] ^ inv_i, in_i[3:0]};
		out_o = truth_i[idx];
	end
endmodule

// >>> logic/rccs_reg_cell.sv
`timescale 1ns/100ps
`include "rccs_defs.svh"

// register cell: edge-selected flop with clear, preset, enable
module rccs_reg_cell (
	input  wire logic ref_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic sel_clk_i,
	input  wire logic fall_i,
	input  wire logic d_i,
	input  wire logic es0_i,
	input  wire logic es1_i,
	input  wire logic clr_i,
	input  wire logic pre_i,
	output logic      q_o
);
	import rccs_pkg::*;

	rccs_cell_st_t st;      // current state
	rccs_cell_st_t next_st; // next state
	logic          edge_hit; // active edge of selected clock
	logic          enable;   // enable from the two select lines

	// edge detect on sampled clock, then priority chain
	always_comb begin
		next_st = st;
		next_st.clk_prev = sel_clk_i;
		// polarity picks which transition counts
		edge_hit = fall_i ? (st.clk_prev & ~sel_clk_i) : (~st.clk_prev & sel_clk_i);
		// select 1 arms gating, select 0 then enables
		enable = ~es1_i | es0_i;
		if (clr_i) begin
			// clear beats preset when both are high
			next_st.q = 1'b0;
		end else if (pre_i) begin
			next_st.q = 1'b1;
		end else if (edge_hit && enable) begin
			// enable sampled on the edge, clock itself untouched
			next_st.q = d_i;
		end
	end

	// state register; clear/preset act without waiting for the cell clock
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q_o = st.q;

	a_clear_wins: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clr_i |=> !q_o) else $error("clear did not force low");
	a_preset_sets: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!clr_i && pre_i |=> q_o) else $error("preset did not force high");
	a_hold_disabled: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!clr_i && !pre_i && !enable |=> $stable(q_o)) else $error("disabled cell changed");
	a_capture_edge: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!clr_i && !pre_i && enable && edge_hit |=> q_o == $past(d_i))
		else $error("active edge missed");
	a_no_edge_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!clr_i && !pre_i && !edge_hit |=> $stable(q_o)) else $error("changed without edge");
endmodule

// >>> verif/rccs_pad_model.sv
`timescale 1ns/100ps

// board side of the clock pads: slow clocks on chosen pads, else tied low
module rccs_pad_model (
	input  wire logic       ref_clk_i,
	input  wire logic [5:0] run_i,
	input  wire logic [5:0] pad_val_i,
	input  wire logic [5:0] pad_oe_i,
	output logic      [5:0] pad_lvl_o
);
	logic [1:0] div;  // divider, keeps pad clock under half the system rate
	logic       pclk; // board clock shared by running pads

	initial begin
		div = 2'h0;
		pclk = 1'b0;
	end

	// pad clock stands low while no pad runs
	always @(posedge ref_clk_i) begin
		div <= (run_i != 6'h0) ? div + 2'h1 : 2'h0;
		if (run_i == 6'h0)
			pclk <= 1'b0;
		else if (div == 2'h3)
			pclk <= ~pclk;
	end

	// a driven pad shows the device value; idle pads tied low, never floating
	assign pad_lvl_o = (pad_oe_i & pad_val_i) | (~pad_oe_i & run_i & {6{pclk}});
endmodule

// >>> verif/test_register_cell_clock_select.sv
`timescale 1ns/100ps
`include "rccs_defs.svh"

// directed bench: registers, pads and register cells
module test_register_cell_clock_select;
	import rccs_pkg::*;
	logic        ref_clk_i; // system clock
	logic        sys_rst_i; // synchronous reset
	logic [7:0]  addr;      // register address
	logic [31:0] wdata;     // write data
	logic        wr;        // write strobe
	logic        rd;        // read strobe
	logic [31:0] rdata;     // read data
	logic        hclk;      // hardwired clock level
	logic [5:0]  pin_i;     // pad levels
	logic [5:0]  pin_o;     // pad output values
	logic [5:0]  pin_oe;    // pad drive enables
	logic [11:0] data;      // lookup data bits
	logic [3:0]  dbin;      // invertible lookup input
	logic [3:0]  es0;       // enable select 0
	logic [3:0]  es1;       // enable select 1
	logic [3:0]  clr;       // asynchronous clear
	logic [3:0]  pre;       // asynchronous preset
	logic [3:0]  q;         // cell outputs
	logic [5:0]  run;       // pads whose board clock runs
	logic [31:0] v;         // last read value
	int          fails;     // mismatches
	int          n_checks;  // comparisons

	rccs_clock_fabric dut (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.reg_addr_i(addr),
		.reg_wdata_i(wdata),
		.reg_wr_i(wr),
		.reg_rd_i(rd),
		.reg_rdata_o(rdata),
		.hardwired_clock_i(hclk),
		.clk_pin_i(pin_i),
		.clk_pin_o(pin_o),
		.clk_pin_oe_o(pin_oe),
		.cell_data_i(data),
		.invertible_logic_input_i(dbin),
		.enable_select_0_i(es0),
		.enable_select_1_i(es1),
		.async_clear_i(clr),
		.async_preset_i(pre),
		.cell_q_o(q)
	);

	rccs_pad_model pads (
		.ref_clk_i(ref_clk_i),
		.run_i(run),
		.pad_val_i(pin_o),
		.pad_oe_i(pin_oe),
		.pad_lvl_o(pin_i)
	);

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// one write cycle, strobe dropped at the next edge
	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task rreg(input logic [7:0] a);
		@(posedge ref_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		@(negedge ref_clk_i);
		v = rdata;
		@(posedge ref_clk_i);
	endtask

	// look at the cells once the edge updates have landed
	task chq(input logic [3:0] e);
		@(negedge ref_clk_i);
		chk({28'h0, q}, {28'h0, e});
		@(posedge ref_clk_i);
	endtask

	// one slow hardwired clock period
	task hpulse;
		@(posedge ref_clk_i);
		hclk <= 1'b1;
		cyc(4);
		hclk <= 1'b0;
		cyc(4);
	endtask

	// short clear or preset pulse
	task zap(input logic [3:0] c, input logic [3:0] p);
		@(posedge ref_clk_i);
		clr <= c;
		pre <= p;
		cyc(3);
		clr <= 4'h0;
		pre <= 4'h0;
	endtask

	// reset values, unmapped and read-only places
	task t_regs;
		logic [7:0] al [5];
		al = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h80};
		wreg(8'h80, 32'hffff_ffff);
		wreg(`RCCS_OFS_STAT, 32'hffff_ffff);
		foreach (al[i]) begin
			rreg(al[i]);
			chk(v, 32'h0);
		end
		rreg(`RCCS_OFS_STAT);
		chk({28'h0, v[3:0]}, 32'h0);
	endtask

	// parity with inverter, captured on hardwired rising edges
	task t_lookup;
		logic [31:0] pt;
		logic [4:0]  k;
		for (int i = 0; i < 32; i++) begin
			k = i[4:0];
			pt[i] = ^k[4:1];
		end
		wreg(`RCCS_OFS_TT0, pt);
		for (int i = 0; i < 32; i++) begin
			k = i[4:0];
			wreg(`RCCS_OFS_CELL, {25'h0, k[3], 6'h0});
			data[2:0] <= k[2:0];
			dbin[0] <= k[4];
			hpulse;
			chq({3'h0, ^k});
		end
	endtask

	// falling polarity ignores the rising edge
	task t_pol;
		wreg(`RCCS_OFS_TT0, 32'hffff_ffff);
		wreg(`RCCS_OFS_CELL, 32'h0000_0008);
		zap(4'hf, 4'h0);
		hclk <= 1'b1;
		cyc(4);
		chq(4'h0);
		hclk <= 1'b0;
		cyc(4);
		chq(4'h1);
	endtask

	// every pairing of the two enable selects
	task t_enable;
		logic [1:0] s;
		wreg(`RCCS_OFS_CELL, 32'h0);
		for (int i = 0; i < 4; i++) begin
			s = i[1:0];
			zap(4'hf, 4'h0);
			es1[0] <= s[1];
			es0[0] <= s[0];
			hpulse;
			chq({3'h0, s != 2'b10});
		end
		es1 <= 4'h0;
		es0 <= 4'h0;
	endtask

	// clear and preset with no cell clock edge at all
	task t_async;
		clr <= 4'hf;
		cyc(3);
		chq(4'h0);
		clr <= 4'h0;
		pre <= 4'hf;
		cyc(3);
		chq(4'hf);
		clr <= 4'hf;
		cyc(3);
		chq(4'h0);
		clr <= 4'h0;
		pre <= 4'h0;
	endtask

	// routed clock a from its pad, then from the cell 0 register
	task t_routed;
		wreg(`RCCS_OFS_TT0 + 8'h4, 32'hffff_ffff);
		wreg(`RCCS_OFS_CELL, 32'h0000_0100);
		zap(4'hf, 4'h0);
		run <= 6'h01;
		cyc(24);
		run <= 6'h00;
		chq(4'h2);
		wreg(`RCCS_OFS_CTRL, 32'h0000_0002);
		zap(4'h0, 4'h1);
		rreg(`RCCS_OFS_STAT);
		chk({31'h0, v[`RCCS_STAT_NETA]}, 32'h1);
		zap(4'h1, 4'h0);
		rreg(`RCCS_OFS_STAT);
		chk({31'h0, v[`RCCS_STAT_NETA]}, 32'h0);
	endtask

	// pad drive per variant; one quadrant clock shared by two cells
	task t_pads;
		wreg(`RCCS_OFS_CTRL, 32'h0);
		wreg(`RCCS_OFS_PIN, 32'h0000_3f2a);
		@(negedge ref_clk_i);
		chk({26'h0, pin_oe}, 32'h3c);
		chk({26'h0, pin_o & pin_oe}, 32'h28);
		wreg(`RCCS_OFS_CTRL, 32'h0000_0119);
		@(negedge ref_clk_i);
		chk({26'h0, pin_oe}, 32'h3b);
		wreg(8'h18, 32'hffff_ffff);
		wreg(8'h1c, 32'hffff_ffff);
		wreg(`RCCS_OFS_CELL, 32'h0303_0000);
		zap(4'hf, 4'h0);
		run <= 6'h04;
		cyc(24);
		run <= 6'h00;
		chq(4'hc);
	endtask

	task complete_run;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// 20 MHz system clock
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	// main sequence
	initial begin
		fails = 0;
		n_checks = 0;
		sys_rst_i = 1'b1;
		addr = 8'h0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		hclk = 1'b0;
		data = 12'h0;
		dbin = 4'h0;
		es0 = 4'h0;
		es1 = 4'h0;
		clr = 4'h0;
		pre = 4'h0;
		run = 6'h0;
		cyc(8);
		sys_rst_i <= 1'b0;
		t_regs;
		t_lookup;
		t_pol;
		t_enable;
		t_async;
		t_routed;
		t_pads;
		complete_run;
	end

	// watchdog, well past the expected run length
	initial begin
		#(4000 * 50);
		fails++;
		complete_run;
	end
endmodule
